// ### rail_seq_pkg.sv
// constants and types for the rail power-down sequencer
//
// How it works
// - pos gate rail step field, bits 7-6
// - pos source rail step field, bits 5-4
// - neg gate rail step field, bits 3-2
// - neg source rail step field, bits 1-0
// - order register resets to 1eh
// - gap three-four: 6/12/24/48 ms, bits 7-6
// - gap two-three: 6/12/24/48 ms, bits 5-4
// - gap one-two: 6/12/24/48 ms, bits 3-2
// - first delay bit 1: 3 or 6 ms
// - bit 0 stretches later gaps x16
// - delay register resets to e0h
package rail_seq_pkg;

  // ----------------------------------------------------------------
  // register map (index, byte address is four times index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_ORDER   = 6'h0b;
  localparam logic [5:0] IDX_DELAYS  = 6'h0c;
  localparam logic [5:0] IDX_STATUS  = 6'h20;
  localparam int         ADDR_LSB    = 2;
  localparam int         ADDR_MSB    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ORDER_RST   = 8'h1e;
  localparam logic [7:0] DELAYS_RST  = 8'he0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_GATE_STOP_LSB   = 6;
  localparam int POS_SOURCE_STOP_LSB = 4;
  localparam int NEG_GATE_STOP_LSB   = 2;
  localparam int NEG_SOURCE_STOP_LSB = 0;
  localparam int GAP_THREE_FOUR_LSB  = 6;
  localparam int GAP_TWO_THREE_LSB   = 4;
  localparam int GAP_ONE_TWO_LSB     = 2;
  localparam int FIRST_DELAY_BIT     = 1;
  localparam int STRETCH_BIT         = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         TICK_PERIOD_MS  = 1;
  localparam int         NS_PER_MS       = 1000000;
  localparam int         MS_CYCLES       = (TICK_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam logic [9:0] FIRST_SHORT_MS  = 10'd3;
  localparam logic [9:0] FIRST_LONG_MS   = 10'd6;
  localparam logic [9:0] GAP_BASE_MS     = 10'd6;
  localparam int         STRETCH_SHIFT   = 4;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_OFF,
    S_ON,
    S_WAIT
  } seq_e;

endpackage : rail_seq_pkg

// ### ms_tick_gen.sv
// millisecond enable pulse divider
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = rail_seq_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic clr,
  // pulse out
  output logic      tick
);
  import rail_seq_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } div_s;

  div_s div_r;
  div_s div_nxt;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    div_nxt      = div_r;
    div_nxt.tick = 1'b0;
    if (clr) begin
      div_nxt.cnt = 32'h0;
    end else if (div_r.cnt == 32'(CYCLES - 1)) begin
      div_nxt.cnt  = 32'h0;
      div_nxt.tick = 1'b1;
    end else begin
      div_nxt.cnt = div_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = div_r.tick;

endmodule : ms_tick_gen

// ### rail_power_down_sequencer.sv
// rail power-down sequencer with ahb-lite register slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rail_power_down_sequencer #(
  parameter int MS_CYCLES = rail_seq_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // wake request
  input  wire logic        sleep_exit_request,
  // rail enables
  output logic             pos_gate_rail,
  output logic             pos_source_rail,
  output logic             neg_gate_rail,
  output logic             neg_source_rail,
  // step pulses
  output logic             stop_step_one,
  output logic             stop_step_two,
  output logic             stop_step_three,
  output logic             stop_step_four
);
  import rail_seq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  order;
    logic [7:0]  delays;
    seq_e        st;
    logic [1:0]  step;
    logic [9:0]  ms_cnt;
    logic [9:0]  target;
    logic [3:0]  rails_on;
    logic [3:0]  strobe;
    logic        wr_pend;
    logic [5:0]  wr_idx;
    logic [31:0] rdata;
    logic        ready;
  } seq_s;

  seq_s st_r;
  seq_s st_nxt;

  logic tick;
  logic tick_clr;

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  assign tick_clr = (st_r.st != S_WAIT);

  ms_tick_gen #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (tick_clr),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // step code of a rail, rail 0 = pos gate ... rail 3 = neg source
  function automatic logic [1:0] stop_code(input logic [7:0] ord, input int rail);
    logic [1:0] c;
    c = 2'h0;
    case (rail)
      0:       c = ord[POS_GATE_STOP_LSB +: 2];
      1:       c = ord[POS_SOURCE_STOP_LSB +: 2];
      2:       c = ord[NEG_GATE_STOP_LSB +: 2];
      default: c = ord[NEG_SOURCE_STOP_LSB +: 2];
    endcase
    return c;
  endfunction : stop_code

  // gap ahead of step idx (1..3), in ms
  function automatic logic [9:0] gap_ms(input logic [7:0] dly, input logic [1:0] idx);
    logic [1:0] code;
    logic [9:0] ms;
    code = 2'h0;
    case (idx)
      2'd1:    code = dly[GAP_ONE_TWO_LSB +: 2];
      2'd2:    code = dly[GAP_TWO_THREE_LSB +: 2];
      default: code = dly[GAP_THREE_FOUR_LSB +: 2];
    endcase
    ms = GAP_BASE_MS << code;
    if (dly[STRETCH_BIT]) begin
      ms = ms << STRETCH_SHIFT;
    end
    return ms;
  endfunction : gap_ms

  // register read mux
  function automatic logic [31:0] reg_read(input seq_s s, input logic [5:0] idx);
    logic [31:0] d;
    d = 32'h0;
    case (idx)
      IDX_ORDER:  d = {24'h0, s.order};
      IDX_DELAYS: d = {24'h0, s.delays};
      IDX_STATUS: d = {24'h0, (s.st == S_WAIT), (s.st != S_OFF), s.step, s.rails_on};
      default:    d = 32'h0;
    endcase
    return d;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       addr_ok;
  logic       acc;
  logic [5:0] acc_idx;

  assign addr_ok = (haddr[31:ADDR_MSB + 1] == '0);
  assign acc     = hsel && htrans[1] && hready;
  assign acc_idx = haddr[ADDR_MSB:ADDR_LSB];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.strobe = 4'h0;
    st_nxt.ready  = 1'b1;

    // data phase of a write
    if (st_r.wr_pend && hready) begin
      st_nxt.wr_pend = 1'b0;
      case (st_r.wr_idx)
        IDX_ORDER:  st_nxt.order  = hwdata[7:0];
        IDX_DELAYS: st_nxt.delays = hwdata[7:0];
        default:    st_nxt.order  = st_nxt.order;
      endcase
    end

    // address phase
    if (acc) begin
      st_nxt.wr_pend = hwrite && addr_ok;
      st_nxt.wr_idx  = acc_idx;
      if (!hwrite) begin
        st_nxt.rdata = addr_ok ? reg_read(st_nxt, acc_idx) : 32'h0;
      end
    end

    // sequencer
    case (st_r.st)
      S_OFF: begin
        if (sleep_exit_request) begin
          st_nxt.st       = S_ON;
          st_nxt.rails_on = 4'hf;
        end
      end
      S_ON: begin
        if (!sleep_exit_request) begin
          st_nxt.st     = S_WAIT;
          st_nxt.step   = 2'd0;
          st_nxt.ms_cnt = 10'd0;
          // first delay 3 or 6 ms
          st_nxt.target = st_r.delays[FIRST_DELAY_BIT] ? FIRST_LONG_MS : FIRST_SHORT_MS;
        end
      end
      S_WAIT: begin
        if (sleep_exit_request) begin
          st_nxt.st       = S_ON;
          st_nxt.rails_on = 4'hf;
        end else if (tick) begin
          if (st_r.ms_cnt + 10'd1 >= st_r.target) begin
            for (int i = 0; i < 4; i++) begin
              if (stop_code(st_r.order, i) == st_r.step) begin
                st_nxt.rails_on[i] = 1'b0;
              end
            end
            st_nxt.strobe[st_r.step] = 1'b1;
            st_nxt.ms_cnt            = 10'd0;
            if (st_r.step == 2'd3) begin
              st_nxt.st = S_OFF;
            end else begin
              st_nxt.step   = st_r.step + 2'd1;
              st_nxt.target = gap_ms(st_r.delays, st_r.step + 2'd1);
            end
          end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 10'd1;
          end
        end
      end
      default: begin
        st_nxt.st = S_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= '0;
      st_r.order  <= ORDER_RST;
      st_r.delays <= DELAYS_RST;
      st_r.st     <= S_OFF;
      st_r.ready  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout       = st_r.ready;
  assign hrdata          = st_r.rdata;
  assign hresp           = 1'b0;
  assign pos_gate_rail   = st_r.rails_on[0];
  assign pos_source_rail = st_r.rails_on[1];
  assign neg_gate_rail   = st_r.rails_on[2];
  assign neg_source_rail = st_r.rails_on[3];
  assign stop_step_one   = st_r.strobe[0];
  assign stop_step_two   = st_r.strobe[1];
  assign stop_step_three = st_r.strobe[2];
  assign stop_step_four  = st_r.strobe[3];

endmodule : rail_power_down_sequencer

// ### rail_seq_chk.sv
// assertion checker for the rail power-down sequencer
`timescale 1ns/1ps
module rail_seq_chk #(
  parameter int MS_CYCLES = 20
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request, rails, steps
  input wire logic sleep_exit_request,
  input wire logic pos_gate_rail,
  input wire logic pos_source_rail,
  input wire logic neg_gate_rail,
  input wire logic neg_source_rail,
  input wire logic stop_step_one,
  input wire logic stop_step_two,
  input wire logic stop_step_three,
  input wire logic stop_step_four
);
  localparam int M = MS_CYCLES;
  logic [3:0] rails;
  logic [3:0] steps;
  logic [2:0] cnt_r;
  int         since_r;
  int         gap_r;
  assign rails = {pos_gate_rail, pos_source_rail, neg_gate_rail, neg_source_rail};
  assign steps = {stop_step_four, stop_step_three, stop_step_two, stop_step_one};
  // ------------------
  // counters
  // ------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= 3'h0;
      since_r <= 0;
      gap_r   <= 0;
    end else begin
      cnt_r   <= sleep_exit_request ? 3'h0 : cnt_r + {2'h0, |steps};
      since_r <= sleep_exit_request ? 0 : since_r + 1;
      gap_r   <= (|steps) ? 1 : gap_r + 1;
    end
  end
  // ------------------
  // properties
  // ------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_all_on;
    rails == 4'hf;
  endsequence
  a_wake_all_on: assert property (sleep_exit_request |=> s_all_on)
    else $error("rails not on");
  a_req_no_step: assert property (sleep_exit_request |=> steps == 4'h0)
    else $error("step while requested");
  a_fall_at_step: assert property ((|($past(rails) & ~rails)) |-> (|steps))
    else $error("rail dropped off step");
  a_rise_together: assert property ((|(rails & ~$past(rails))) |-> s_all_on)
    else $error("partial rail rise");
  a_steps_in_order: assert property ((|steps) |-> steps == (4'h1 << cnt_r))
    else $error("step out of order");
  a_first_delay: assert property (stop_step_one |-> since_r == 3*M+2 || since_r == 6*M+2)
    else $error("first delay wrong");
  a_gap_values: assert property ((|steps[3:1]) |-> gap_r inside {6*M, 12*M, 24*M, 48*M, 96*M, 192*M, 384*M, 768*M})
    else $error("gap wrong");
  a_last_all_off: assert property (stop_step_four |-> rails == 4'h0)
    else $error("rail left on");
endmodule : rail_seq_chk
bind rail_power_down_sequencer rail_seq_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .sleep_exit_request(sleep_exit_request),
  .pos_gate_rail(pos_gate_rail), .pos_source_rail(pos_source_rail), .neg_gate_rail(neg_gate_rail),
  .neg_source_rail(neg_source_rail), .stop_step_one(stop_step_one), .stop_step_two(stop_step_two),
  .stop_step_three(stop_step_three), .stop_step_four(stop_step_four));

// ### testbench.sv
// self-checking bench for the rail power-down sequencer
`timescale 1ns/1ps
module testbench;
  import rail_seq_pkg::*;
  localparam int          MS    = 20;
  localparam logic [31:0] A_ORD = {24'h0, IDX_ORDER, 2'b00};
  localparam logic [31:0] A_DLY = {24'h0, IDX_DELAYS, 2'b00};
  typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d;} row_s;
  logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, sleep_exit_request;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  rails, steps;
  int          n_fail, cmp_count;
  row_s        rows [9] = '{'{1'b0, A_ORD, {24'h0, ORDER_RST}}, '{1'b0, A_DLY, {24'h0, DELAYS_RST}},
    '{1'b1, A_ORD, 32'hffff_ff5a}, '{1'b0, A_ORD, 32'h0000_005a}, '{1'b1, A_DLY, 32'h0000_00a5},
    '{1'b0, A_DLY, 32'h0000_00a5}, '{1'b1, 32'h0000_0100, 32'h0000_0077},
    '{1'b0, 32'h0000_0100, 32'h0000_0000}, '{1'b0, A_ORD, 32'h0000_005a}};
  rail_power_down_sequencer #(.MS_CYCLES(MS)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp),
    .sleep_exit_request(sleep_exit_request), .pos_gate_rail(rails[3]), .pos_source_rail(rails[2]),
    .neg_gate_rail(rails[1]), .neg_source_rail(rails[0]), .stop_step_one(steps[0]),
    .stop_step_two(steps[1]), .stop_step_three(steps[2]), .stop_step_four(steps[3]));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ------------------
  // tasks
  // ------------------
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int i;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    for (int p = 0; p < 2; p++) begin
      i = 0;
      do begin
        @(posedge hclk);
        i++;
      end while (hrdy !== 1'b1 && i < 50);
      if (hrdy !== 1'b1) begin
        n_fail++;
        tally_and_finish();
      end
      if (p == 0) begin
        htrans <= 2'b00;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask : bus
  task automatic run_seq(input logic [7:0] ord, input logic [7:0] dly);
    int         t [4];
    int         k;
    logic [3:0] m;
    t[0] = dly[1] ? 6 : 3;
    for (int j = 1; j < 4; j++) t[j] = t[j-1] + (6 << dly[2*j +: 2]) * (dly[0] ? 16 : 1);
    bus(1'b1, A_ORD, {24'h0, ord});
    bus(1'b1, A_DLY, {24'h0, dly});
    sleep_exit_request <= 1'b1;
    repeat (3) @(posedge hclk);
    @(posedge hclk);
    sleep_exit_request <= 1'b0;
    k = 0;
    for (int c = 1; c < t[3] * MS + 20 && k < 4; c++) begin
      @(posedge hclk);
      #1;
      if (steps !== 4'h0) begin
        for (int r = 0; r < 4; r++) m[r] = ord[2*r +: 2] > k;
        chk(32'(steps), 32'h1 << k);
        chk(c, t[k] * MS + 2);
        chk(32'(rails), 32'(m));
        k++;
      end
    end
    if (k < 4) begin
      n_fail++;
      tally_and_finish();
    end
    $display("sequence %h %h done", ord, dly);
    @(posedge hclk);
  endtask : run_seq
  // ------------------
  // main sequence
  // ------------------
  initial begin
    {hresetn, hsel, hwrite, sleep_exit_request} = 4'h4;
    {htrans, haddr, hwdata} = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    #1 chk(32'(rails), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd, rows[i].d);
      chk(32'(hresp), 32'h0);
    end
    $display("register rows done");
    run_seq(8'h0f, 8'h13);
    sleep_exit_request <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, A_DLY, 32'h0);
    chk(rd, {24'h0, DELAYS_RST});
    sleep_exit_request <= 1'b0;
    repeat (80) @(posedge hclk);
    #1 chk(32'(rails), 32'h7);
    @(posedge hclk);
    sleep_exit_request <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk(32'(rails), 32'hf);
    @(posedge hclk);
    bus(1'b0, {24'h0, IDX_STATUS, 2'b00}, 32'h0);
    chk(rd, 32'h0000_005f);
    $display("reset and abort done");
    @(posedge hclk);
    run_seq(ORDER_RST, DELAYS_RST);
    tally_and_finish();
  end
endmodule : testbench
